// File: tocu_core.sv
/*
 * 16-bit timer with two output compare channels, byte-wide register access.
 * Assumes tick_i is a one-cycle enable from a prescaler on mclk_i and that
 * irq_ack_i pulses come from the interrupt controller on the same clock.
 */
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps

// What this block does
// RL1 - Compare count with each compare value continuously
// RL2 - Match sets flag on following tick
// RL3 - Enabled flag requests interrupt; service clears it
// RL4 - Writing one clears flag; zero keeps it
// RL5 - Output from match, mode, action, top, bottom
// RL6 - Compare A may define the counter top
// RL7 - Buffered in PWM modes, direct otherwise
// RL8 - Buffer loads active value at top/bottom
// RL9 - Bus reaches buffer or compare register
// RL10 - Only writes change compare; high read direct
// RL11 - Software writes high first, reads low first
// RL12 - High write to holding; low write commits
// RL13 - Force acts on output, no flag, non-PWM
// RL14 - Count write blocks matches next tick
// RL15 - Software avoids writing count equal to top
// RL16 - Output state survives mode change; resets zero
// RL17 - Action bits unbuffered; apply at next match
// RL18 - Nonzero action overrides port value, not direction
// RL19 - Action zero leaves output state unchanged
// RL20 - Mode steers counting; action only output
// RL21 - Normal mode counts up, wraps at max
// RL22 - Normal mode overflow set when count reaches zero
// RL23 - Clock source zero stops ticks; bus works
// RL24 - Count write beats clear or count
// RL25 - Per-tick updates qualified by tick enable
module tocu_core
   import tocu_pkg::*;
(
   // Clock and reset
   input  wire  logic          mclk_i,
   input  wire  logic          rst_i,
   // Prescaler and interrupt service
   input  wire  logic          tick_i,
   input  wire  logic [2:0]    irq_ack_i,
   // Avalon-MM slave
   input  wire  logic [3:0]    avs_address_i,
   input  wire  logic          avs_read_i,
   input  wire  logic          avs_write_i,
   input  wire  logic [7:0]    avs_writedata_i,
   output logic       [7:0]    avs_readdata_o,
   output logic                avs_waitrequest_o,
   // Interrupt requests: overflow, compare A, compare B
   output logic       [2:0]    irq_o,
   // Compare pins
   output logic       [1:0]    pin_out_o,
   output logic       [1:0]    pin_oe_o
);
   import tocu_pkg::*;

   typedef struct packed {
      logic             wait_n;
      logic [7:0]       rdata;
      logic [7:0]       temp;
      logic [15:0]      cnt;
      logic             dir_up;
      logic [1:0][15:0] cmp;
      logic [1:0][15:0] cbuf;
      logic [15:0]      cap;
      logic [1:0][1:0]  act;
      logic [3:0]       mode;
      logic [2:0]       cs;
      logic [2:0]       flags;
      logic [2:0]       ien;
      logic [1:0]       port;
      logic [1:0]       ddr;
      logic             block;
      logic [1:0]       oc;
      logic [2:0]       irq;
      logic [1:0]       pin;
      logic [1:0]       oe;
   } tocu_state_t;

   tocu_state_t st;
   tocu_state_t next_st;
   logic [1:0]  match;
   logic        tick;
   logic        acc;
   logic        wr;
   logic [15:0] top;
   logic        at_top;

   // RL1 full-width compare
   for (genvar g = 0; g < 2; g++) begin : g_cmp
      assign match[g] = (st.cnt == st.cmp[g]);
   end

   // RL23 stopped source yields no tick
   assign tick   = tick_i && (st.cs != CS_STOP);
   assign acc    = (avs_read_i || avs_write_i) && st.wait_n;
   assign wr     = acc && avs_write_i;
   // RL6 compare A may set the top
   assign top    = top_of(st.mode, st.cmp[0], st.cap);
   // RL15 a blocked tick misses the top
   assign at_top = (st.cnt == top) && !st.block;

   always_comb begin
      logic [1:0] hit;
      logic       reload;
      logic [2:0] set_f;
      next_st = st;
      hit     = 2'b00;
      reload  = 1'b0;
      set_f   = 3'h0;
      // Answer one cycle after the request is seen
      next_st.wait_n = !acc;

      // RL25 counting only on tick
      if (tick) begin
         next_st.block = 1'b0;
         // RL14 blocked for this tick
         hit = match & {2{!st.block}};
         // RL20 mode alone picks sequence
         if (is_dual(st.mode)) begin
            if (st.dir_up) begin
               if (st.cnt >= top) begin
                  next_st.dir_up = 1'b0;
                  next_st.cnt    = st.cnt - 16'h0001;
                  reload         = !is_pfc(st.mode);
               end else begin
                  next_st.cnt = st.cnt + 16'h0001;
               end
            end else if (st.cnt == CNT_RESET) begin
               next_st.dir_up          = 1'b1;
               next_st.cnt             = st.cnt + 16'h0001;
               set_f[FLAG_OVF]         = 1'b1;
               reload                  = is_pfc(st.mode);
            end else begin
               next_st.cnt = st.cnt - 16'h0001;
            end
         end else if (st.mode != MODE_NORMAL && at_top) begin
            next_st.cnt = CNT_RESET;
            reload      = is_pwm(st.mode);
            if (is_pwm(st.mode)) begin
               set_f[FLAG_OVF] = 1'b1;
            end
         end else begin
            // RL21 plain upward count, wraps
            next_st.cnt = st.cnt + 16'h0001;
            // RL22 overflow as count becomes zero
            if (st.cnt == CNT_MAX) begin
               set_f[FLAG_OVF] = 1'b1;
            end
         end
      end

      // RL8 reload only at top or bottom
      if (reload) begin
         next_st.cmp = st.cbuf;
      end

      // RL5 waveform per channel
      for (int c = 0; c < 2; c++) begin
         if (!is_pwm(st.mode)) begin
            // RL13 force acts like a match, no flag
            if (hit[c] || (wr && avs_address_i == REG_FORCE
                           && avs_writedata_i[FLD_FORCE + 1 - c])) begin
               // RL19 action zero does nothing
               unique case (st.act[c])
                  ACT_TOGGLE: next_st.oc[c] = !st.oc[c];
                  ACT_CLEAR:  next_st.oc[c] = 1'b0;
                  ACT_SET:    next_st.oc[c] = 1'b1;
                  default:    next_st.oc[c] = st.oc[c];
               endcase
            end
         end else if (is_dual(st.mode)) begin
            if (hit[c]) begin
               if (st.act[c] == ACT_TOGGLE) begin
                  if (c == 0 && (st.mode == 4'h9 || st.mode == 4'hB)) begin
                     next_st.oc[c] = !st.oc[c];
                  end
               end else if (st.act[c] != 2'h0) begin
                  // Set or clear depends on slope and polarity
                  next_st.oc[c] = st.dir_up ^ (st.act[c] == ACT_CLEAR);
               end
            end
         end else begin
            if (hit[c]) begin
               if (st.act[c] == ACT_TOGGLE) begin
                  if (c == 0 && st.mode == 4'hF) begin
                     next_st.oc[c] = !st.oc[c];
                  end
               end else if (st.act[c] != 2'h0) begin
                  next_st.oc[c] = (st.act[c] == ACT_SET);
               end
            end
            // Bottom action wins so compare at top gives a steady level
            if (tick && at_top && st.act[c][1]) begin
               next_st.oc[c] = (st.act[c] == ACT_CLEAR);
            end
         end
      end

      // RL3 service clears its flag
      next_st.flags = next_st.flags & ~irq_ack_i;

      // Register access
      if (acc && avs_read_i) begin
         unique case (avs_address_i)
            REG_CTRL_A: next_st.rdata = {st.act[0], st.act[1], 2'h0, st.mode[1:0]};
            REG_CTRL_B: next_st.rdata = {3'h0, st.mode[3:2], st.cs};
            REG_CNT_LOW: begin
               next_st.rdata = st.cnt[7:0];
               next_st.temp  = st.cnt[15:8];
            end
            REG_CNT_HIGH: next_st.rdata = st.temp;
            // RL9 buffer when buffered, else active
            // RL10 high byte read directly
            REG_CMPA_LOW: next_st.rdata = is_pwm(st.mode) ? st.cbuf[0][7:0]  : st.cmp[0][7:0];
            REG_CMPA_HI:  next_st.rdata = is_pwm(st.mode) ? st.cbuf[0][15:8] : st.cmp[0][15:8];
            REG_CMPB_LOW: next_st.rdata = is_pwm(st.mode) ? st.cbuf[1][7:0]  : st.cmp[1][7:0];
            REG_CMPB_HI:  next_st.rdata = is_pwm(st.mode) ? st.cbuf[1][15:8] : st.cmp[1][15:8];
            REG_IRQ_EN:  next_st.rdata = {5'h00, st.ien};
            REG_FLAGS:   next_st.rdata = {5'h00, st.flags};
            REG_PORT:    next_st.rdata = {4'h0, st.ddr, st.port};
            REG_CAP_LOW: begin
               next_st.rdata = st.cap[7:0];
               next_st.temp  = st.cap[15:8];
            end
            REG_CAP_HIGH: next_st.rdata = st.temp;
            default:      next_st.rdata = 8'h00;
         endcase
      end

      if (wr) begin
         unique case (avs_address_i)
            REG_CTRL_A: begin
               // RL17 action bits take effect at once
               next_st.act[0]    = avs_writedata_i[FLD_ACT_A +: 2];
               next_st.act[1]    = avs_writedata_i[FLD_ACT_B +: 2];
               // RL16 output state kept across modes
               next_st.mode[1:0] = avs_writedata_i[1:0];
            end
            REG_CTRL_B: begin
               next_st.mode[3:2] = avs_writedata_i[FLD_MODE_H +: 2];
               next_st.cs        = avs_writedata_i[2:0];
            end
            // RL12 high bytes land in holding register
            REG_CNT_HIGH, REG_CMPA_HI, REG_CMPB_HI, REG_CAP_HIGH: begin
               next_st.temp = avs_writedata_i;
            end
            REG_CNT_LOW: begin
               // RL24 count write overrides tick
               next_st.cnt   = {st.temp, avs_writedata_i};
               next_st.block = 1'b1;
            end
            REG_CMPA_LOW, REG_CMPB_LOW: begin
               // RL7 buffer path in PWM modes
               for (int c = 0; c < 2; c++) begin
                  if (avs_address_i == REG_CMPA_LOW + 4'(2 * c)) begin
                     next_st.cbuf[c] = {st.temp, avs_writedata_i};
                     if (!is_pwm(st.mode)) begin
                        next_st.cmp[c] = {st.temp, avs_writedata_i};
                     end
                  end
               end
            end
            REG_CAP_LOW: begin
               if (uses_cap(st.mode)) begin
                  next_st.cap = {st.temp, avs_writedata_i};
               end
            end
            REG_IRQ_EN: next_st.ien = avs_writedata_i[2:0];
            // RL4 write one clears, set beats clear
            REG_FLAGS: begin
               next_st.flags = next_st.flags & ~avs_writedata_i[2:0];
            end
            REG_PORT: begin
               next_st.port = avs_writedata_i[1:0];
               next_st.ddr  = avs_writedata_i[FLD_DIR +: 2];
            end
            default: next_st.temp = st.temp;
         endcase
      end

      // RL2 flag on the tick after the match
      set_f[FLAG_CMP +: 2] = set_f[FLAG_CMP +: 2] | hit;
      // Sets applied after every clear, so a set beats a clear
      next_st.flags        = next_st.flags | set_f;
      // RL3 request while flag and enable
      next_st.irq = next_st.flags & next_st.ien;
      // RL18 port override, direction untouched
      for (int c = 0; c < 2; c++) begin
         next_st.pin[c] = (next_st.act[c] != 2'h0) ? next_st.oc[c] : next_st.port[c];
      end
      next_st.oe = next_st.ddr;
   end

   // State register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st        <= '0;
         st.wait_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata_o    = st.rdata;
   assign avs_waitrequest_o = st.wait_n;
   assign irq_o             = st.irq;
   assign pin_out_o         = st.pin;
   assign pin_oe_o          = st.oe;

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_high_write;
      wr && avs_address_i == REG_CNT_HIGH;
   endsequence
   sequence s_low_write;
      wr && avs_address_i == REG_CNT_LOW;
   endsequence

   // RL12 high write loads holding register
   a_high_to_temp: assert property (s_high_write |=> st.temp == $past(avs_writedata_i))
      else $error("holding register not loaded by high write");
   // RL12 low write commits both bytes at once
   a_count_pair_load: assert property (s_low_write
      |=> st.cnt == {$past(st.temp), $past(avs_writedata_i)})
      else $error("count not loaded from holding and low bytes");
   // RL2 flag follows unblocked match
   a_flag_on_match: assert property (tick && match[0] && !st.block |=> st.flags[FLAG_CMP])
      else $error("compare A flag not set after match");
   // RL14 blocked tick sets no compare flag
   a_block_no_flag: assert property (tick && st.block && !st.flags[FLAG_CMP]
      |=> !st.flags[FLAG_CMP])
      else $error("compare flag set in blocked tick");
   // RL23 stopped counter holds
   a_stopped_hold: assert property (st.cs == CS_STOP && !wr |=> $stable(st.cnt))
      else $error("counter moved while stopped");
   // RL21 normal wrap with overflow
   a_normal_wrap: assert property (tick && st.mode == MODE_NORMAL && st.cnt == CNT_MAX
      && !wr |=> st.cnt == CNT_RESET && st.flags[FLAG_OVF])
      else $error("normal mode wrap or overflow wrong");
   // RL4 write one clears
   a_flag_w1c: assert property (wr && avs_address_i == REG_FLAGS && avs_writedata_i[0]
      && !tick |=> !st.flags[FLAG_OVF])
      else $error("flag not cleared by write of one");
   // RL13 force never sets a flag
   a_force_no_flag: assert property (wr && avs_address_i == REG_FORCE && !tick
      && !st.flags[FLAG_CMP] |=> !st.flags[FLAG_CMP])
      else $error("force set a compare flag");
   // RL18 pin follows output state when overridden
   a_pin_override: assert property (st.act[0] != 2'h0 |-> pin_out_o[0] == st.oc[0])
      else $error("pin not overridden by output state");
   // RL3 request follows flag and enable
   a_irq_request: assert property (st.flags[FLAG_CMP] && st.ien[FLAG_CMP]
      |-> irq_o[FLAG_CMP])
      else $error("interrupt not requested");
   // RL7 direct write in non-PWM modes
   a_direct_write: assert property (wr && avs_address_i == REG_CMPA_LOW
      && !is_pwm(st.mode) |=> st.cmp[0] == {$past(st.temp), $past(avs_writedata_i)})
      else $error("compare not written directly");
   // Bus answers one cycle later
   a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o)
      else $error("waitrequest not lowered after one cycle");
   // RL3 service pulse clears the flag
   a_ack_clears: assert property (irq_ack_i[FLAG_CMP] && !tick |=> !st.flags[FLAG_CMP])
      else $error("compare flag not cleared by service");
   // RL6 compare A top clears the count
   a_match_clear: assert property (tick && !wr && at_top && st.mode != MODE_NORMAL
      && !is_pwm(st.mode) |=> st.cnt == CNT_RESET)
      else $error("count not cleared at compare top");
endmodule : tocu_core

// File: tocu_pkg.sv
/*
 * Constants, register map and mode decoding for the timer output compare
 * block. Assumes an 8-bit Avalon-MM register bus and a prescaler tick.
 */
package tocu_pkg;
   // Register indices, one byte each
   localparam logic [3:0] REG_CTRL_A   = 4'h0; // action A, action B, mode[1:0]
   localparam logic [3:0] REG_CTRL_B   = 4'h1; // mode[3:2], clock source
   localparam logic [3:0] REG_FORCE    = 4'h2; // force strobes, reads zero
   localparam logic [3:0] REG_CNT_LOW  = 4'h3;
   localparam logic [3:0] REG_CNT_HIGH = 4'h4;
   localparam logic [3:0] REG_CMPA_LOW = 4'h5;
   localparam logic [3:0] REG_CMPA_HI  = 4'h6;
   localparam logic [3:0] REG_CMPB_LOW = 4'h7;
   localparam logic [3:0] REG_CMPB_HI  = 4'h8;
   localparam logic [3:0] REG_IRQ_EN   = 4'h9;
   localparam logic [3:0] REG_FLAGS    = 4'hA;
   localparam logic [3:0] REG_PORT     = 4'hB;
   localparam logic [3:0] REG_CAP_LOW  = 4'hC;
   localparam logic [3:0] REG_CAP_HIGH = 4'hD;
   // Field positions
   localparam int FLD_ACT_A  = 6;
   localparam int FLD_ACT_B  = 4;
   localparam int FLD_MODE_H = 3;
   localparam int FLD_DIR    = 2;
   localparam int FLD_FORCE  = 6;
   localparam int FLAG_OVF   = 0;
   localparam int FLAG_CMP   = 1;
   // Reset values and fixed counts
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [2:0]  CS_STOP   = 3'h0;
   localparam logic [3:0]  MODE_NORMAL = 4'h0;
   localparam logic [1:0]  ACT_TOGGLE = 2'h1;
   localparam logic [1:0]  ACT_CLEAR  = 2'h2;
   localparam logic [1:0]  ACT_SET    = 2'h3;

   // Modes that buffer the compare value
   function automatic logic is_pwm(input logic [3:0] m);
      return !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
   endfunction : is_pwm
   // Dual-slope modes
   function automatic logic is_dual(input logic [3:0] m);
      return (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
   endfunction : is_dual
   // Dual-slope modes reloading at bottom
   function automatic logic is_pfc(input logic [3:0] m);
      return m == 4'h8 || m == 4'h9;
   endfunction : is_pfc
   // Modes whose top sits in the capture register
   function automatic logic uses_cap(input logic [3:0] m);
      return m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE;
   endfunction : uses_cap
   // Top value of the counting sequence
   function automatic logic [15:0] top_of(input logic [3:0] m,
                                          input logic [15:0] cmp_a,
                                          input logic [15:0] cap);
      case (m)
         4'h1, 4'h5: return 16'h00FF;
         4'h2, 4'h6: return 16'h01FF;
         4'h3, 4'h7: return 16'h03FF;
         4'h4, 4'h9, 4'hB, 4'hF: return cmp_a;
         4'h8, 4'hA, 4'hC, 4'hE: return cap;
         default: return CNT_MAX;
      endcase
   endfunction : top_of
endpackage : tocu_pkg

// File: tocu_cpu_model.sv
/*
 * Processor-side model for the timer compare block: byte bus master,
 * prescaler tick source and interrupt service pulses.
 * Assumes one clock and a slave that answers with waitrequest low.
 */
`timescale 1ns/100ps
module tocu_cpu_model (
   // Clock
   input  wire logic       mclk_i,
   // Bus answer
   input  wire logic       wait_i,
   input  wire logic [7:0] rdata_i,
   // Bus request
   output logic      [3:0] addr_o,
   output logic            rd_o,
   output logic            wr_o,
   output logic      [7:0] wdata_o,
   // Tick, service and bus watchdog
   output logic            tick_o,
   output logic      [2:0] ack_o,
   output logic            hang_o
);
   // Idle bus at time zero
   initial begin
      addr_o = 4'h0;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      tick_o = 1'b0;
      ack_o = 3'h0;
      hang_o = 1'b0;
   end

   // One transfer; held until waitrequest low is seen at an edge
   task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= w;
      rd_o <= !w;
      // Waitrequest as each rising edge samples it
      do begin
         @(posedge mclk_i);
         n++;
      end while (wait_i !== 1'b0 && n < 50);
      if (n >= 50) hang_o <= 1'b1;
      // Data taken at the edge that sees waitrequest low
      q = rdata_i;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      // Released data must not look valid
      wdata_o <= ~d;
   endtask : xfer

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] unused;
      xfer(a, 1'b1, d, unused);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      xfer(a, 1'b0, 8'h00, q);
   endtask : rd

   task automatic wr16(input logic [3:0] hi, input logic [3:0] lo, input logic [15:0] v);
      wr(hi, v[15:8]);
      wr(lo, v[7:0]);
   endtask : wr16

   task automatic rd16(input logic [3:0] lo, input logic [3:0] hi, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(hi, v[15:8]);
   endtask : rd16

   // Single-cycle ticks with a gap between them
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk_i);
         tick_o <= 1'b1;
         @(posedge mclk_i);
         tick_o <= 1'b0;
      end
   endtask : tick

   task automatic ack(input int i);
      @(posedge mclk_i);
      ack_o <= 3'b001 << i;
      @(posedge mclk_i);
      ack_o <= 3'h0;
   endtask : ack
endmodule : tocu_cpu_model

// File: test_timer16_output_compare_units.sv
/*
 * Self-checking bench for the timer compare block.
 * Assumes the processor model drives every bus, tick and service input.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h, expected %h", $time, (g), (e)); end end
module test_timer16_output_compare_units;
   import tocu_pkg::*;
   logic        mclk_i, rst_i, tick, rd, wr, waitreq, hang;
   logic  [2:0] ack, irq;
   logic  [3:0] addr;
   logic  [7:0] wdata, rdata, q;
   logic  [1:0] pin_out, pin_oe;
   logic [15:0] v;
   int          failures = 0;
   int          samples_checked = 0;

   tocu_core dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .tick_i(tick), .irq_ack_i(ack),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq),
      .pin_out_o(pin_out), .pin_oe_o(pin_oe));
   tocu_cpu_model cpu_u (.mclk_i(mclk_i), .wait_i(waitreq), .rdata_i(rdata), .addr_o(addr),
      .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .tick_o(tick), .ack_o(ack), .hang_o(hang));

   // 10 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   // Let registered outputs settle
   task automatic settle(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : settle

   task automatic t_reset;
      cpu_u.rd(REG_CMPA_HI, q);
      `CHK(q, 8'h00)
      cpu_u.rd(4'hE, q);
      `CHK(q, 8'h00)
      `CHK(pin_out, 2'b00)
      $display("reset test done");
   endtask : t_reset

   task automatic t_cmp_write;
      cpu_u.wr(REG_CMPA_HI, 8'h12);
      cpu_u.rd(REG_CMPA_HI, q);
      `CHK(q, 8'h00)
      cpu_u.wr(REG_CMPA_LOW, 8'h34);
      cpu_u.rd16(REG_CMPA_LOW, REG_CMPA_HI, v);
      `CHK(v, 16'h1234)
      $display("compare write test done");
   endtask : t_cmp_write

   task automatic t_match;
      cpu_u.wr16(REG_CMPA_HI, REG_CMPA_LOW, 16'h0005);
      cpu_u.wr16(REG_CNT_HIGH, REG_CNT_LOW, 16'h0003);
      cpu_u.wr(REG_FLAGS, 8'h07);
      cpu_u.wr(REG_CTRL_B, 8'h01);
      cpu_u.tick(2);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP], 1'b0)
      cpu_u.tick(1);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP], 1'b1)
      cpu_u.wr(REG_FLAGS, 8'h00);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP], 1'b1)
      cpu_u.wr(REG_IRQ_EN, 8'h02);
      settle(2);
      `CHK(irq, 3'b010)
      cpu_u.ack(1);
      settle(2);
      `CHK(irq, 3'b000)
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP], 1'b0)
      cpu_u.wr(REG_IRQ_EN, 8'h00);
      $display("match test done");
   endtask : t_match

   task automatic t_block;
      cpu_u.wr(REG_CTRL_B, 8'h00);
      cpu_u.wr16(REG_CNT_HIGH, REG_CNT_LOW, 16'h0005);
      cpu_u.tick(1);
      cpu_u.rd16(REG_CNT_LOW, REG_CNT_HIGH, v);
      `CHK(v, 16'h0005)
      cpu_u.wr(REG_CTRL_B, 8'h01);
      cpu_u.tick(1);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP], 1'b0)
      cpu_u.rd16(REG_CNT_LOW, REG_CNT_HIGH, v);
      `CHK(v, 16'h0006)
      cpu_u.wr16(REG_CNT_HIGH, REG_CNT_LOW, 16'hFFFF);
      cpu_u.tick(1);
      cpu_u.rd16(REG_CNT_LOW, REG_CNT_HIGH, v);
      `CHK(v, 16'h0000)
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_OVF], 1'b1)
      cpu_u.wr(REG_FLAGS, 8'h01);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_OVF], 1'b0)
      cpu_u.wr16(REG_CNT_HIGH, REG_CNT_LOW, 16'hFFFF);
      cpu_u.tick(1);
      cpu_u.wr(REG_IRQ_EN, 8'h01);
      settle(2);
      `CHK(irq, 3'b001)
      cpu_u.ack(0);
      settle(2);
      `CHK(irq, 3'b000)
      cpu_u.wr(REG_IRQ_EN, 8'h00);
      $display("blocking test done");
   endtask : t_block

   task automatic t_force;
      cpu_u.wr(REG_CTRL_B, 8'h00);
      cpu_u.wr(REG_PORT, 8'h04);
      cpu_u.wr(REG_CTRL_A, {ACT_TOGGLE, 6'h00});
      cpu_u.wr(REG_FORCE, 8'h80);
      settle(2);
      `CHK(pin_out[0], 1'b1)
      `CHK(pin_oe, 2'b01)
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP], 1'b0)
      cpu_u.wr(REG_FORCE, 8'h80);
      cpu_u.wr(REG_CTRL_A, 8'h00);
      cpu_u.wr(REG_FORCE, 8'h80);
      cpu_u.wr(REG_CTRL_A, {ACT_SET, 6'h00});
      settle(2);
      `CHK(pin_out[0], 1'b0)
      cpu_u.wr(REG_PORT, 8'h05);
      settle(2);
      `CHK(pin_out[0], 1'b0)
      cpu_u.wr(REG_CTRL_A, 8'h00);
      settle(2);
      `CHK(pin_out[0], 1'b1)
      cpu_u.wr(REG_PORT, 8'h04);
      cpu_u.wr(REG_CTRL_A, {ACT_SET, 6'h00});
      cpu_u.wr(REG_FORCE, 8'h80);
      cpu_u.wr(REG_CTRL_A, {ACT_TOGGLE, 6'h01});
      cpu_u.wr(REG_FORCE, 8'h80);
      settle(2);
      `CHK(pin_out[0], 1'b1)
      $display("force test done");
   endtask : t_force

   task automatic t_top_a;
      cpu_u.wr(REG_CTRL_A, 8'h00);
      cpu_u.wr(REG_CTRL_B, 8'h08);
      cpu_u.wr16(REG_CMPA_HI, REG_CMPA_LOW, 16'h0003);
      cpu_u.wr16(REG_CNT_HIGH, REG_CNT_LOW, 16'h0000);
      cpu_u.wr(REG_CTRL_B, 8'h09);
      cpu_u.tick(4);
      cpu_u.rd16(REG_CNT_LOW, REG_CNT_HIGH, v);
      `CHK(v, 16'h0000)
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP], 1'b1)
      cpu_u.wr(REG_CTRL_B, 8'h00);
      $display("top from compare test done");
   endtask : t_top_a

   task automatic t_buffer;
      cpu_u.wr(REG_CTRL_A, 8'h00);
      cpu_u.wr16(REG_CMPB_HI, REG_CMPB_LOW, 16'h0100);
      cpu_u.wr(REG_CTRL_A, 8'h01);
      cpu_u.wr16(REG_CMPB_HI, REG_CMPB_LOW, 16'h000A);
      cpu_u.rd(REG_CMPB_LOW, q);
      `CHK(q, 8'h0A)
      // count start kept off the top value
      cpu_u.wr16(REG_CNT_HIGH, REG_CNT_LOW, 16'h0009);
      cpu_u.wr(REG_FLAGS, 8'h07);
      cpu_u.wr(REG_CTRL_B, 8'h09);
      cpu_u.tick(2);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP+1], 1'b0)
      cpu_u.tick(255);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP+1], 1'b0)
      cpu_u.tick(1);
      cpu_u.rd(REG_FLAGS, q);
      `CHK(q[FLAG_CMP+1], 1'b1)
      cpu_u.wr(REG_IRQ_EN, 8'h04);
      settle(2);
      `CHK(irq, 3'b100)
      cpu_u.ack(2);
      settle(2);
      `CHK(irq, 3'b000)
      $display("buffer test done");
   endtask : t_buffer

   // Verdict and end of run
   task automatic test_done;
      if (hang !== 1'b0) failures++;
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // Reset, then the scenarios in turn
   initial begin
      rst_i = 1'b1;
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_reset();
      t_cmp_write();
      t_match();
      t_block();
      t_force();
      t_top_a();
      t_buffer();
      test_done();
   end

   // Watchdog: the scenarios need well under 5000 cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      failures++;
      test_done();
   end
endmodule : test_timer16_output_compare_units
